// ---- hdl/ansi_param_serial_slave_regs.vh ----
/*
 Constants for the character-protocol parameter slave: control characters,
 data-field limits, protocol modes and register map.
 Assumes inclusion by ansi_param_serial_slave.v and by the testbench's checker and test modules.
*/
`ifndef ANSI_PARAM_SERIAL_SLAVE_REGS_VH
`define ANSI_PARAM_SERIAL_SLAVE_REGS_VH

// ----------------------------------------------------------------
// Control characters
// ----------------------------------------------------------------
`define CH_STX          8'h02
`define CH_ETX          8'h03
`define CH_EOT          8'h04
`define CH_ENQ          8'h05
`define CH_ACK          8'h06
`define CH_NAK          8'h15
`define CH_ZERO         8'h30
`define CH_NINE         8'h39
`define CH_SPACE        8'h20
`define CH_PLUS         8'h2b
`define CH_MINUS        8'h2d
`define CH_POINT        8'h2e

// ----------------------------------------------------------------
// Data field and checksum limits
// ----------------------------------------------------------------
`define MAX_FIELD_LEN   4'd12
`define MAX_DIGITS      4'd10
`define MAX_FRAC        4'd9
`define MAX_DP          3'd6
`define CHK_FLOOR       8'h20
`define POS_LIMIT       56'h0000007fffffff
`define NEG_LIMIT       56'h00000080000000

// ----------------------------------------------------------------
// Protocol modes and error code
// ----------------------------------------------------------------
`define MODE_FOUR_WIRE  4'h1
`define MODE_TWO_WIRE   4'h2
`define ERR_BAD_MODE    8'h31

// ----------------------------------------------------------------
// Register map (byte addresses) and reset values
// ----------------------------------------------------------------
`define REG_CTRL        8'h00
`define REG_BAUD        8'h04
`define REG_STATUS      8'h08
`define REG_COUNT       8'h0c
`define CTRL_MODE_LSB   0
`define CTRL_ADDR_LO    8
`define CTRL_ADDR_HI    12
`define STAT_ERR_BIT    0
`define STAT_CODE_LSB   8
`define STAT_BUSY_BIT   16
`define RST_MODE        4'h1
`define RST_ADDR_HI     4'h1
`define RST_ADDR_LO     4'h1
`define RST_BAUD        32'h00000004

`endif

// ---- hdl/ansi_param_serial_slave.v ----
/*
 Slave handler for a character-framed parameter read/write protocol on a
 multidrop serial line, with an APB register file for configuration.
 Assumes a character receiver/transmitter outside, synchronous to clock_i,
 and a parameter store that answers a held request with par_ack_i.
*/
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`include "ansi_param_serial_slave_regs.vh"

module ansi_param_serial_slave #(
	parameter BUF_DEPTH = 20
) (
	input  wire        clock_i,
	input  wire        rst_i,
	input  wire        psel_i,
	input  wire        penable_i,
	input  wire        pwrite_i,
	input  wire [7:0]  paddr_i,
	input  wire [31:0] pwdata_i,
	output reg  [31:0] prdata_o,
	output reg         pready_o,
	output reg         pslverr_o,
	input  wire [7:0]  rx_data_i,
	input  wire        rx_valid_i,
	output reg  [7:0]  tx_data_o,
	output reg         tx_valid_o,
	input  wire        tx_ready_i,
	output reg         line_drive_o,
	output reg         four_wire_o,
	output reg  [31:0] baud_cfg_o,
	output reg         par_req_o,
	output reg         par_we_o,
	output reg  [6:0]  par_menu_o,
	output reg  [6:0]  par_num_o,
	output reg  [31:0] par_wdata_o,
	input  wire        par_ack_i,
	input  wire        par_exists_i,
	input  wire        par_ok_i,
	input  wire [2:0]  par_dp_i,
	input  wire [31:0] par_rdata_i
);

// ----------------------------------------------------------------
// States
// ----------------------------------------------------------------
localparam S_IDLE  = 12'h001;
localparam S_ADDR  = 12'h002;
localparam S_SEL   = 12'h004;
localparam S_RHDR  = 12'h008;
localparam S_WHDR  = 12'h010;
localparam S_DATA  = 12'h020;
localparam S_CHK   = 12'h040;
localparam S_LOOK  = 12'h080;
localparam S_RESC  = 12'h100;
localparam S_WRITE = 12'h200;
localparam S_FMT   = 12'h400;
localparam S_TX    = 12'h800;

// ----------------------------------------------------------------
// Declarations
// ----------------------------------------------------------------
reg  [11:0] st_reg;
reg  [3:0]  pos_reg;
reg  [7:0]  ah_reg, al_reg;
reg         addr_bad_reg, hdr_bad_reg, is_write_reg;
reg  [3:0]  m_hi_reg, m_lo_reg, p_hi_reg, p_lo_reg;
reg  [7:0]  xor_reg;
reg  [3:0]  len_reg, ndig_reg, frac_reg;
reg         seen_reg, dp_seen_reg, neg_reg, bad_reg;
reg  [34:0] raw_reg;
reg  [3:0]  dig_mem [0:9];
reg  [2:0]  dp_reg;
reg  [55:0] scaled_reg;
reg  [4:0]  ridx_reg, keep_reg, steps_reg;
reg  [31:0] mag_reg;
reg  [3:0]  k_reg, fdig_reg;
reg         started_reg, dot_reg, tail_reg;
reg  [7:0]  buf_mem [0:BUF_DEPTH-1];
reg  [4:0]  tl_reg, ti_reg;
reg         quiet_reg;
reg  [3:0]  mode_reg, own_hi_reg, own_lo_reg;
reg         err_reg;
reg  [15:0] count_reg;

wire        two_wire = (mode_reg == `MODE_TWO_WIRE);
wire        rx_take  = rx_valid_i & (st_reg != S_TX);
wire        is_dig   = (rx_data_i >= `CH_ZERO) && (rx_data_i <= `CH_NINE);
wire [3:0]  dval     = rx_data_i[3:0];
wire [7:0]  chk_fix  = (xor_reg < `CHK_FLOOR) ? xor_reg + `CHK_FLOOR : xor_reg;
wire [31:0] pow_k    = pow10(k_reg);
wire [3:0]  xfrac    = (frac_reg > {1'b0, par_dp_i}) ? frac_reg - {1'b0, par_dp_i} : 4'd0;
wire [3:0]  xpad     = ({1'b0, par_dp_i} > frac_reg) ? {1'b0, par_dp_i} - frac_reg : 4'd0;
wire [55:0] limit    = neg_reg ? `NEG_LIMIT : `POS_LIMIT;
wire        apb_setup = psel_i & ~penable_i;
wire [3:0]  wmode    = pwdata_i[`CTRL_MODE_LSB+3:`CTRL_MODE_LSB];
wire [6:0]  menu_bin = {m_hi_reg, 3'b000} + {2'b00, m_hi_reg, 1'b0} + {3'b000, m_lo_reg};
wire [6:0]  num_bin  = {p_hi_reg, 3'b000} + {2'b00, p_hi_reg, 1'b0} + {3'b000, p_lo_reg};

function [31:0] pow10;
	input [3:0] k;
	begin
		case (k)
			4'd0: pow10 = 32'h00000001;
			4'd1: pow10 = 32'h0000000a;
			4'd2: pow10 = 32'h00000064;
			4'd3: pow10 = 32'h000003e8;
			4'd4: pow10 = 32'h00002710;
			4'd5: pow10 = 32'h000186a0;
			4'd6: pow10 = 32'h000f4240;
			4'd7: pow10 = 32'h00989680;
			4'd8: pow10 = 32'h05f5e100;
			default: pow10 = 32'h3b9aca00;
		endcase
	end
endfunction

// ----------------------------------------------------------------
// APB slave and configuration
// ----------------------------------------------------------------
// Zero wait: read data is caught in the setup cycle, so it comes from a flop.
always @(posedge clock_i or posedge rst_i) begin
	if (rst_i) begin
		prdata_o    <= 32'h00000000;
		pready_o    <= 1'b0;
		pslverr_o   <= 1'b0;
		mode_reg    <= `RST_MODE;
		own_hi_reg  <= `RST_ADDR_HI;
		own_lo_reg  <= `RST_ADDR_LO;
		baud_cfg_o  <= `RST_BAUD;
		err_reg     <= 1'b0;
		four_wire_o <= 1'b1;
	end else begin
		pready_o  <= apb_setup;
		pslverr_o <= apb_setup & (paddr_i[7:4] != 4'h0 || paddr_i[1:0] != 2'b00);
		if (apb_setup) begin
			case (paddr_i)
				`REG_CTRL:   prdata_o <= {16'h0000, own_hi_reg, own_lo_reg, 4'h0, mode_reg};
				`REG_BAUD:   prdata_o <= baud_cfg_o;
				`REG_STATUS: prdata_o <= {15'h0000, st_reg != S_IDLE,
					err_reg ? `ERR_BAD_MODE : 8'h00, 7'h00, err_reg};
				`REG_COUNT:  prdata_o <= {16'h0000, count_reg};
				default:     prdata_o <= 32'h00000000;
			endcase
		end
		if (psel_i & penable_i & pready_o & pwrite_i) begin
			case (paddr_i)
				`REG_CTRL: begin
					own_hi_reg <= pwdata_i[`CTRL_ADDR_HI+3:`CTRL_ADDR_HI];
					own_lo_reg <= pwdata_i[`CTRL_ADDR_LO+3:`CTRL_ADDR_LO];
					if (wmode == `MODE_FOUR_WIRE || wmode == `MODE_TWO_WIRE) begin
						mode_reg <= wmode;
					end else begin
						mode_reg <= `MODE_FOUR_WIRE;
						err_reg  <= 1'b1;
					end
				end
				`REG_BAUD: baud_cfg_o <= pwdata_i;
				`REG_STATUS: begin
					if (pwdata_i[`STAT_ERR_BIT] &&
					    (wmode == `MODE_FOUR_WIRE || wmode == `MODE_TWO_WIRE))
						err_reg <= 1'b0;
				end
				default: ;
			endcase
		end
		four_wire_o <= ~two_wire;
	end
end

// ----------------------------------------------------------------
// Request parser, parameter access and reply builder
// ----------------------------------------------------------------
task push;
	input [7:0] c;
	begin
		buf_mem[tl_reg] <= c;
		xor_reg <= xor_reg ^ c;
		tl_reg <= tl_reg + 5'd1;
	end
endtask

task reply1;
	input [7:0] c;
	begin
		buf_mem[0] <= c;
		tl_reg <= 5'd1;
		ti_reg <= 5'd0;
		st_reg <= quiet_reg ? S_IDLE : S_TX;
	end
endtask

always @(posedge clock_i or posedge rst_i) begin
	if (rst_i) begin
		st_reg <= S_IDLE;
		pos_reg <= 4'd0;
		ah_reg <= 8'h00;
		al_reg <= 8'h00;
		addr_bad_reg <= 1'b0;
		hdr_bad_reg <= 1'b0;
		is_write_reg <= 1'b0;
		m_hi_reg <= 4'd0;
		m_lo_reg <= 4'd0;
		p_hi_reg <= 4'd0;
		p_lo_reg <= 4'd0;
		xor_reg <= 8'h00;
		len_reg <= 4'd0;
		ndig_reg <= 4'd0;
		frac_reg <= 4'd0;
		seen_reg <= 1'b0;
		dp_seen_reg <= 1'b0;
		neg_reg <= 1'b0;
		bad_reg <= 1'b0;
		raw_reg <= 35'd0;
		dp_reg <= 3'd0;
		scaled_reg <= 56'd0;
		ridx_reg <= 5'd0;
		keep_reg <= 5'd0;
		steps_reg <= 5'd0;
		mag_reg <= 32'h00000000;
		k_reg <= 4'd0;
		fdig_reg <= 4'd0;
		started_reg <= 1'b0;
		dot_reg <= 1'b0;
		tail_reg <= 1'b0;
		tl_reg <= 5'd0;
		ti_reg <= 5'd0;
		quiet_reg <= 1'b0;
		count_reg <= 16'h0000;
		par_req_o <= 1'b0;
		par_we_o <= 1'b0;
		par_menu_o <= 7'd0;
		par_num_o <= 7'd0;
		par_wdata_o <= 32'h00000000;
		tx_data_o <= 8'h00;
		tx_valid_o <= 1'b0;
		line_drive_o <= 1'b0;
	end else begin
		// Two-wire drives only while sending; four-wire keeps its own pair
		line_drive_o <= ~two_wire | (st_reg == S_TX);
		if (rx_take && rx_data_i == `CH_EOT && (st_reg == S_IDLE || st_reg == S_ADDR ||
		    st_reg == S_SEL || st_reg == S_RHDR || st_reg == S_WHDR ||
		    st_reg == S_DATA || st_reg == S_CHK)) begin
			st_reg <= S_ADDR;
			pos_reg <= 4'd0;
			addr_bad_reg <= 1'b0;
			hdr_bad_reg <= 1'b0;
			xor_reg <= 8'h00;
			len_reg <= 4'd0;
			ndig_reg <= 4'd0;
			frac_reg <= 4'd0;
			seen_reg <= 1'b0;
			dp_seen_reg <= 1'b0;
			neg_reg <= 1'b0;
			bad_reg <= 1'b0;
			raw_reg <= 35'd0;
		end else begin
			case (st_reg)
				S_IDLE: ;
				S_ADDR: if (rx_take) begin
					pos_reg <= pos_reg + 4'd1;
					if (pos_reg == 4'd0) ah_reg <= rx_data_i;
					if (pos_reg == 4'd2) al_reg <= rx_data_i;
					if ((pos_reg == 4'd1 && rx_data_i != ah_reg) ||
					    (pos_reg == 4'd3 && rx_data_i != al_reg) || !is_dig)
						addr_bad_reg <= 1'b1;
					if (pos_reg == 4'd3) st_reg <= S_SEL;
				end
				S_SEL: if (rx_take) begin
					pos_reg <= 4'd1;
					quiet_reg <= !(ah_reg == {4'h3, own_hi_reg} && al_reg == {4'h3, own_lo_reg});
					if (!((ah_reg == {4'h3, own_hi_reg} && (al_reg == {4'h3, own_lo_reg} ||
					    al_reg == `CH_ZERO)) || (ah_reg == `CH_ZERO && al_reg == `CH_ZERO)))
						addr_bad_reg <= 1'b1;
					if (rx_data_i == `CH_STX) begin
						is_write_reg <= 1'b1;
						pos_reg <= 4'd0;
						st_reg <= S_WHDR;
					end else begin
						is_write_reg <= 1'b0;
						m_hi_reg <= dval;
						hdr_bad_reg <= !is_dig;
						st_reg <= S_RHDR;
					end
				end
				S_RHDR, S_WHDR: if (rx_take) begin
					pos_reg <= pos_reg + 4'd1;
					if (st_reg == S_WHDR) xor_reg <= xor_reg ^ rx_data_i;
					if (pos_reg == 4'd0) m_hi_reg <= dval;
					if (pos_reg == 4'd1) m_lo_reg <= dval;
					if (pos_reg == 4'd2) p_hi_reg <= dval;
					if (pos_reg == 4'd3) p_lo_reg <= dval;
					if (pos_reg < 4'd4 && !is_dig) hdr_bad_reg <= 1'b1;
					if (st_reg == S_WHDR && pos_reg == 4'd3) st_reg <= S_DATA;
					if (st_reg == S_RHDR && pos_reg == 4'd4) begin
						if (rx_data_i == `CH_ENQ && !hdr_bad_reg && !addr_bad_reg)
							st_reg <= S_LOOK;
						else
							st_reg <= S_IDLE;
					end
				end
				S_DATA: if (rx_take) begin
					xor_reg <= xor_reg ^ rx_data_i;
					if (rx_data_i == `CH_ETX) begin
						st_reg <= S_CHK;
						if (ndig_reg == 4'd0 || raw_reg > {limit[34:0]}) bad_reg <= 1'b1;
					end else begin
						len_reg <= len_reg + 4'd1;
						if (len_reg == `MAX_FIELD_LEN) bad_reg <= 1'b1;
						if (rx_data_i == `CH_SPACE) begin
							if (seen_reg) bad_reg <= 1'b1;
						end else begin
							seen_reg <= 1'b1;
							if (rx_data_i == `CH_PLUS || rx_data_i == `CH_MINUS) begin
								if (seen_reg) bad_reg <= 1'b1;
								neg_reg <= (rx_data_i == `CH_MINUS);
							end else if (rx_data_i == `CH_POINT) begin
								if (dp_seen_reg) bad_reg <= 1'b1;
								dp_seen_reg <= 1'b1;
							end else if (is_dig) begin
								if (ndig_reg == `MAX_DIGITS) begin
									bad_reg <= 1'b1;
								end else begin
									ndig_reg <= ndig_reg + 4'd1;
									dig_mem[ndig_reg] <= dval;
									raw_reg <= (raw_reg << 3) + (raw_reg << 1) + {31'd0, dval};
								end
								if (dp_seen_reg) begin
									frac_reg <= frac_reg + 4'd1;
									if (frac_reg == `MAX_FRAC) bad_reg <= 1'b1;
								end
							end else begin
								bad_reg <= 1'b1;
							end
						end
					end
				end
				S_CHK: if (rx_take) begin
					if (rx_data_i == chk_fix && !addr_bad_reg && !hdr_bad_reg)
						st_reg <= S_LOOK;
					else
						st_reg <= S_IDLE;
				end
				S_LOOK: begin
					par_req_o <= ~par_ack_i;
					par_we_o <= 1'b0;
					par_menu_o <= menu_bin;
					par_num_o <= num_bin;
					if (par_req_o && par_ack_i) begin
						dp_reg <= (par_dp_i > `MAX_DP) ? `MAX_DP : par_dp_i;
						count_reg <= count_reg + 16'h0001;
						if (!par_exists_i) begin
							reply1(is_write_reg ? `CH_NAK : `CH_EOT);
						end else if (is_write_reg) begin
							if (bad_reg) begin
								reply1(`CH_NAK);
							end else begin
								st_reg <= S_RESC;
								ridx_reg <= 5'd0;
								scaled_reg <= 56'd0;
								keep_reg <= {1'b0, ndig_reg - xfrac};
								steps_reg <= {1'b0, ndig_reg - xfrac} + {1'b0, xpad};
							end
						end else begin
							buf_mem[0] <= `CH_STX;
							buf_mem[1] <= {4'h3, m_hi_reg};
							buf_mem[2] <= {4'h3, m_lo_reg};
							buf_mem[3] <= {4'h3, p_hi_reg};
							buf_mem[4] <= {4'h3, p_lo_reg};
							buf_mem[5] <= `CH_MINUS;
							neg_reg <= par_rdata_i[31];
							mag_reg <= par_rdata_i[31] ? 32'h00000000 - par_rdata_i : par_rdata_i;
							tl_reg <= par_rdata_i[31] ? 5'd6 : 5'd5;
							xor_reg <= {4'h0, m_hi_reg ^ m_lo_reg ^ p_hi_reg ^ p_lo_reg} ^
								(par_rdata_i[31] ? `CH_MINUS : 8'h00);
							k_reg <= 4'd9;
							fdig_reg <= 4'd0;
							started_reg <= 1'b0;
							dot_reg <= 1'b0;
							tail_reg <= 1'b0;
							st_reg <= S_FMT;
						end
					end
				end
				S_RESC: begin
					// Surplus fraction digits are never fed in; missing ones enter as zeros
					if (ridx_reg == steps_reg) begin
						if (scaled_reg > limit) begin
							reply1(`CH_NAK);
						end else begin
							par_wdata_o <= neg_reg ? 32'h00000000 - scaled_reg[31:0] :
								scaled_reg[31:0];
							st_reg <= S_WRITE;
						end
					end else begin
						ridx_reg <= ridx_reg + 5'd1;
						scaled_reg <= (scaled_reg << 3) + (scaled_reg << 1) +
							((ridx_reg < keep_reg) ? {52'd0, dig_mem[ridx_reg[3:0]]} : 56'd0);
					end
				end
				S_WRITE: begin
					par_req_o <= ~par_ack_i;
					par_we_o <= 1'b1;
					if (par_req_o && par_ack_i)
						reply1(par_ok_i ? `CH_ACK : `CH_NAK);
				end
				S_FMT: begin
					if (tail_reg) begin
						buf_mem[tl_reg] <= chk_fix;
						tl_reg <= tl_reg + 5'd1;
						ti_reg <= 5'd0;
						st_reg <= quiet_reg ? S_IDLE : S_TX;
					end else if (k_reg == 4'd15) begin
						// Last digit wraps the counter, so the frame closes here
						push(`CH_ETX);
						tail_reg <= 1'b1;
					end else if (mag_reg >= pow_k && !(k_reg == 4'd0 && fdig_reg == 4'd9)) begin
						mag_reg <= mag_reg - pow_k;
						fdig_reg <= fdig_reg + 4'd1;
					end else if (dp_reg != 3'd0 && k_reg == {1'b0, dp_reg} - 4'd1 && !dot_reg) begin
						push(`CH_POINT);
						dot_reg <= 1'b1;
						started_reg <= 1'b1;
					end else if (started_reg || fdig_reg != 4'd0 || k_reg <= {1'b0, dp_reg}) begin
						push({4'h3, fdig_reg});
						started_reg <= 1'b1;
						fdig_reg <= 4'd0;
						k_reg <= k_reg - 4'd1;
					end else begin
						k_reg <= k_reg - 4'd1;
					end
				end
				S_TX: begin
					// A character counts as sent once the transmitter has taken it
					if (!tx_valid_o || tx_ready_i) begin
						if (ti_reg == tl_reg) begin
							tx_valid_o <= 1'b0;
							st_reg <= S_IDLE;
						end else begin
							tx_data_o <= buf_mem[ti_reg];
							tx_valid_o <= 1'b1;
							ti_reg <= ti_reg + 5'd1;
						end
					end
				end
				default: st_reg <= S_IDLE;
			endcase
		end
	end
end

endmodule

// ---- tb/ansi_param_serial_slave_props.sv ----
/*
 Concurrent checks on the ports of the character-protocol parameter slave.
 Assumes the bind below and one clock domain with asynchronous reset.
*/
`timescale 1ns/100ps
`include "ansi_param_serial_slave_regs.vh"
module ansi_param_serial_slave_props (
	input wire logic        clock_i,
	input wire logic        rst_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [7:0]  paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	input wire logic [7:0]  tx_data_o,
	input wire logic        tx_valid_o,
	input wire logic        tx_ready_i,
	input wire logic        line_drive_o,
	input wire logic        four_wire_o,
	input wire logic [31:0] baud_cfg_o,
	input wire logic        par_req_o,
	input wire logic        par_we_o,
	input wire logic [6:0]  par_menu_o,
	input wire logic [6:0]  par_num_o,
	input wire logic        par_ack_i,
	input wire logic        par_ok_i
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	wire acc = psel_i & penable_i;
	wire bad = paddr_i != `REG_CTRL && paddr_i != `REG_BAUD && paddr_i != `REG_STATUS
		&& paddr_i != `REG_COUNT;
	wire wr_done = par_req_o && par_we_o && par_ack_i;

	a_apb_zero_wait: assert property (acc |-> pready_o)
		else $error("access cycle without ready");
	a_bad_addr_err: assert property (acc && bad |-> pslverr_o && prdata_o == 32'h0)
		else $error("unmapped access not refused");
	a_mode_fallback: assert property (acc && pwrite_i && paddr_i == `REG_CTRL
		&& pwdata_i[3:0] != 4'h1 && pwdata_i[3:0] != 4'h2 |=> ##1 four_wire_o)
		else $error("bad mode not forced to four-wire");
	a_baud_update: assert property (acc && pwrite_i && paddr_i == `REG_BAUD
		|=> baud_cfg_o == $past(pwdata_i))
		else $error("bit rate setting not taken");
	// Driver enable resets low while four_wire_o resets high, so it lags by one edge after reset
	a_four_drive: assert property (four_wire_o && $past(four_wire_o) && !$past(rst_i)
		|-> line_drive_o)
		else $error("four-wire line not driven");
	a_reply_on_line: assert property (tx_valid_o |-> line_drive_o)
		else $error("reply without line driver");
	a_tx_held: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
		else $error("reply character dropped before ready");
	a_req_held: assert property (par_req_o && !par_ack_i
		|=> par_req_o && $stable(par_menu_o) && $stable(par_num_o))
		else $error("parameter request not held");
	a_write_ack: assert property (wr_done && par_ok_i |-> ##[1:8] tx_valid_o && tx_data_o == `CH_ACK)
		else $error("accepted write not acknowledged");
	a_write_nak: assert property (wr_done && !par_ok_i |-> ##[1:8] tx_valid_o && tx_data_o == `CH_NAK)
		else $error("refused write not answered with not-acknowledge");

	c_write_ok: cover property (wr_done && par_ok_i);
	c_missing: cover property (tx_valid_o && tx_data_o == `CH_EOT);
	c_refused: cover property (acc && pslverr_o);
endmodule

bind ansi_param_serial_slave ansi_param_serial_slave_props i_ansi_param_serial_slave_props (
	.clock_i(clock_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
	.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
	.pready_o(pready_o), .pslverr_o(pslverr_o), .tx_data_o(tx_data_o),
	.tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .line_drive_o(line_drive_o),
	.four_wire_o(four_wire_o), .baud_cfg_o(baud_cfg_o), .par_req_o(par_req_o),
	.par_we_o(par_we_o), .par_menu_o(par_menu_o), .par_num_o(par_num_o),
	.par_ack_i(par_ack_i), .par_ok_i(par_ok_i));

// ---- tb/param_store_model.sv ----
/*
 Parameter store behind the slave: three parameters, alternating fast and
 slow answers. Assumes the requester holds its request until acknowledged.
*/
`timescale 1ns/100ps
module param_store_model (
	input  wire logic        clock_i,
	input  wire logic        rst_i,
	input  wire logic        par_req_i,
	input  wire logic        par_we_i,
	input  wire logic [6:0]  par_menu_i,
	input  wire logic [6:0]  par_num_i,
	input  wire logic [31:0] par_wdata_i,
	output logic             par_ack_o,
	output logic             par_exists_o,
	output logic             par_ok_o,
	output logic [2:0]       par_dp_o,
	output logic [31:0]      par_rdata_o
);
	logic [31:0] val_reg [4];
	logic [3:0]  wait_reg;
	logic        slow_reg;
	logic [1:0]  sel;
	always_comb begin
		sel = (par_menu_i == 7'd1 && par_num_i == 7'd2) ? 2'd0 :
			(par_menu_i == 7'd18 && par_num_i == 7'd11) ? 2'd1 :
			(par_menu_i == 7'd20 && par_num_i == 7'd1) ? 2'd2 : 2'd3;
		par_exists_o = sel != 2'd3;
		// Narrow range so that some legal fields still get refused
		par_ok_o = par_exists_o && $signed(par_wdata_i) <= 100000
			&& $signed(par_wdata_i) >= -100000;
		par_dp_o = (sel == 2'd0) ? 3'd1 : (sel == 2'd2) ? 3'd3 : 3'd0;
		par_rdata_o = par_ack_o ? val_reg[sel] : ~val_reg[sel];
	end
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			val_reg <= '{32'd123, -32'sd45, 32'd0, 32'd0};
			wait_reg <= 4'h0;
			slow_reg <= 1'b0;
			par_ack_o <= 1'b0;
		end else begin
			par_ack_o <= par_req_i && !par_ack_o && wait_reg >= (slow_reg ? 4'h5 : 4'h0);
			wait_reg <= (par_req_i && !par_ack_o) ? wait_reg + 4'h1 : 4'h0;
			if (par_ack_o)
				slow_reg <= !slow_reg;
			if (par_ack_o && par_we_i && par_ok_o)
				val_reg[sel] <= par_wdata_i;
		end
	end
endmodule

// ---- tb/test_ansi_param_serial_slave.sv ----
/*
 Testbench: APB master, character sender, reply collector with stalls.
 Assumes the parameter store model and zero-free request strings.
*/
`timescale 1ns/100ps
`include "ansi_param_serial_slave_regs.vh"
module test_ansi_param_serial_slave;
	logic clock_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
	logic [7:0] paddr_i = 0, rx_data_i = 0, tx_data_o;
	logic [31:0] pwdata_i = 0, prdata_o, baud_cfg_o, par_wdata_o, par_rdata_i, q;
	logic rx_valid_i = 0, tx_ready_i = 0, pready_o, pslverr_o, tx_valid_o, line_drive_o, e;
	logic four_wire_o, par_req_o, par_we_o, par_ack_i, par_exists_i, par_ok_i;
	logic [6:0] par_menu_o, par_num_o;
	logic [2:0] par_dp_i;
	logic [255:0] rep = 0;
	logic clr = 0;
	logic [127:0] bad [6] = '{"1 2", "1234567890123", ".1234567890", "12345678901",
		"2147483648", "200000"};
	int fail_count = 0, samples_checked = 0, cycles = 0;

	ansi_param_serial_slave i_ansi_param_serial_slave (.clock_i(clock_i), .rst_i(rst_i),
		.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i), .tx_data_o(tx_data_o),
		.tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .line_drive_o(line_drive_o),
		.four_wire_o(four_wire_o), .baud_cfg_o(baud_cfg_o), .par_req_o(par_req_o),
		.par_we_o(par_we_o), .par_menu_o(par_menu_o), .par_num_o(par_num_o),
		.par_wdata_o(par_wdata_o), .par_ack_i(par_ack_i), .par_exists_i(par_exists_i),
		.par_ok_i(par_ok_i), .par_dp_i(par_dp_i), .par_rdata_i(par_rdata_i));
	param_store_model i_param_store_model (.clock_i(clock_i), .rst_i(rst_i),
		.par_req_i(par_req_o), .par_we_i(par_we_o), .par_menu_i(par_menu_o),
		.par_num_i(par_num_o), .par_wdata_i(par_wdata_o), .par_ack_o(par_ack_i),
		.par_exists_o(par_exists_i), .par_ok_o(par_ok_i), .par_dp_o(par_dp_i),
		.par_rdata_o(par_rdata_i));

	// ----------------------------------------------------------------
	// Clock, stalls, reply capture, timeout
	// ----------------------------------------------------------------
	always #5 clock_i = ~clock_i;
	always @(posedge clock_i) tx_ready_i <= ~tx_ready_i;
	always @(posedge clock_i) begin
		if (clr)
			rep <= 0;
		else if (tx_valid_o === 1'b1 && tx_ready_i)
			rep <= {rep[247:0], tx_data_o};
	end
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			close_out;
		end
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic close_out;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [255:0] got, input logic [255:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	// Zero bytes are padding only; no protocol character is zero
	function automatic logic [255:0] pack(input logic [255:0] v);
		logic [255:0] r;
		r = 0;
		for (int i = 31; i >= 0; i--) if (v[i*8+:8] != 0) r = {r[247:0], v[i*8+:8]};
		return r;
	endfunction
	function automatic logic [7:0] cks(input logic [255:0] v);
		logic [7:0] x;
		x = 0;
		for (int i = 0; i < 32; i++) x ^= v[i*8+:8];
		return (x < 8'h20) ? x + 8'h20 : x;
	endfunction
	function automatic logic [255:0] rpl(input logic [127:0] b);
		return {`CH_STX, b, `CH_ETX, cks({b, `CH_ETX})};
	endfunction
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		psel_i <= 1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clock_i);
		penable_i <= 1;
		do
			@(posedge clock_i);
		while (pready_o !== 1'b1);
		q = prdata_o;
		e = pslverr_o;
		psel_i <= 0;
		penable_i <= 0;
	endtask
	task automatic send(input logic [255:0] v);
		for (int i = 31; i >= 0; i--) if (v[i*8+:8] != 0) begin
			@(posedge clock_i);
			rx_data_i <= v[i*8+:8];
			rx_valid_i <= 1;
			@(posedge clock_i);
			rx_valid_i <= 0;
		end
	endtask
	// Silence must be watched for a window, so the wait is fixed here
	task automatic xfer(input logic [255:0] v, input logic [255:0] exp);
		@(posedge clock_i);
		clr <= 1;
		@(posedge clock_i);
		clr <= 0;
		send(v);
		repeat (200) @(posedge clock_i);
		chk(rep, pack(exp));
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] mp, input logic [255:0] exp);
		xfer({`CH_EOT, a[15:8], a[15:8], a[7:0], a[7:0], mp, `CH_ENQ}, exp);
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] mp, input logic [127:0] d,
		input logic [255:0] exp);
		xfer({`CH_EOT, a[15:8], a[15:8], a[7:0], a[7:0], `CH_STX, mp, d, `CH_ETX,
			cks({mp, d, `CH_ETX})}, exp);
	endtask

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (12) @(posedge clock_i);
		rst_i <= 0;
		apb(0, `REG_CTRL, 0); chk({e, q}, {1'b0, 32'h1101});
		apb(0, `REG_BAUD, 0); chk({e, q}, {1'b0, 32'h4});
		apb(0, `REG_STATUS, 0); chk({e, q}, 0);
		chk({four_wire_o, line_drive_o}, 2'b11);
		rd("11", "0102", rpl("010212.3"));
		rd("11", "0909", `CH_EOT);
		rd("11", "1811", rpl("1811-45"));
		wr("11", "0102", "+1.2345", `CH_ACK);
		rd("11", "0102", rpl("01021.2"));
		wr("11", "2001", "  -1.2", `CH_ACK);
		rd("11", "2001", rpl("2001-1.200"));
		wr("11", "1811", "7", `CH_ACK);
		for (int i = 0; i < 6; i++) wr("11", "1811", bad[i], `CH_NAK);
		wr("11", "0909", "1", `CH_NAK);
		rd("11", "1811", rpl("18117"));
		xfer({`CH_EOT, "1111", `CH_STX, "18115", `CH_ETX, cks({"18115", `CH_ETX}) ^ 8'h01}, 0);
		xfer({`CH_EOT, "1211", "0102", `CH_ENQ}, 0);
		rd("22", "0102", 0);
		rd("00", "0102", 0);
		rd("10", "0102", 0);
		send({`CH_EOT, "111101"});
		rd("11", "0102", rpl("01021.2"));
		apb(0, `REG_COUNT, 0); chk(q, 32'h13);
		apb(1, `REG_CTRL, 32'h1107);
		apb(0, `REG_CTRL, 0); chk(q, 32'h1101);
		apb(0, `REG_STATUS, 0); chk(q, 32'h3101);
		apb(1, `REG_STATUS, 32'h1);
		apb(0, `REG_STATUS, 0); chk(q, 0);
		apb(1, `REG_CTRL, 32'h2302);
		apb(0, `REG_CTRL, 0); chk({four_wire_o, line_drive_o}, 2'b00);
		rd("23", "0102", rpl("01021.2"));
		rd("11", "0102", 0);
		apb(1, `REG_BAUD, 32'h1c200);
		@(posedge clock_i);
		chk(baud_cfg_o, 32'h1c200);
		apb(0, 8'h10, 0); chk({e, q}, {1'b1, 32'h0});
		close_out;
	end
endmodule
